/* File: inc/fbd_params.svh */
// Constants for the fieldbus diagnostic and master state block.
`ifndef FBD_PARAMS_SVH
`define FBD_PARAMS_SVH
`define FBD_OFF_STATUS 8'h00
`define FBD_OFF_PAYLOAD 8'h04
`define FBD_OFF_PAYLOAD_HI 8'h08
`define FBD_OFF_CTRL 8'h0C
`define FBD_OFF_BASE 8'h10
`define FBD_OFF_STATE 8'h14
`define FBD_OFF_DIAG_MSG 8'h18
`define FBD_BIT_VALID 0
`define FBD_BIT_DELETE 1
`define FBD_STATUS_IGNORED 8'h03
`define FBD_MSG_USER_VALID 8'h40
`define FBD_MSG_NONE 8'h00
`define FBD_CTRL_RUN 0
`define FBD_CTRL_PARAMS 1
`define FBD_CTRL_CONFIG 2
`define FBD_CTRL_HWCFG 3
`define FBD_BLINK_HALF_NS 250000000
`define FBD_CLK_PERIOD_NS 5
`define FBD_MIN_KBPS 32'h0000000A
`define FBD_MAX_KBPS 32'h00002EE0
`endif

/* File: inc/fbd_pkg.sv */
// Types for the fieldbus diagnostic and master state block.
package fbd_pkg;
  typedef enum logic [1:0] {FBD_GC_NONE, FBD_GC_CLEAR, FBD_GC_OPERATE} fbd_gc_t;
  typedef enum logic [1:0] {FBD_OFFLINE, FBD_ONLINE, FBD_EXCHANGE} fbd_mstate_t;
  typedef struct packed {
    logic [15:0] base;
    logic [7:0] status;
    logic [39:0] payload;
  } fbd_diag_t;
  typedef struct packed {
    fbd_gc_t gc;
    logic zero_len;
    logic zero_data;
    logic send_out;
    logic copy_in;
  } fbd_cycle_t;
endpackage : fbd_pkg

/* File: rtl/fbd_core.sv */
// Fieldbus diagnostic release and master state control with an Avalon-MM register slave.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fbd_params.svh"
// Notes on behaviour
// - On a diagnostic, write six-byte block: status byte then five user bytes.
// - Block placement in the process image comes from a configured base address.
// - Status bit 0 rising from 0 to 1 sends the diagnostic to master.
// - Status value 03h is ignored and sends nothing.
// - Status bit 0 marks user data valid and starts a diagnostic.
// - Status bit 1 requests deletion of the diagnostic.
// - Status bits 2 to 7 are reserved without function.
// - Block bytes 1 to 5 equal frame bytes 11 to 15.
// - After reset the interface is inactive and all indicators are dark.
// - With bus parameters, go online, light run indicator, answer at station address.
// - Valid slave configuration enters data exchange, shown on exchange indicator.
// - Power-on and each new hardware configuration pass parameters to master.
// - In STOP broadcast Clear and blink the exchange indicator.
// - In STOP fail-safe slaves get a zero-length output telegram.
// - In STOP other slaves get full telegrams with outputs forced to zero.
// - In STOP slave inputs keep copying into the CPU input area.
// - In RUN broadcast Operate and keep exchange indicator steadily lit.
// - In RUN each slave gets cyclic telegrams with latest outputs.
// - In RUN slave inputs are cyclically copied to the CPU input area.
// - One common bit rate between 9.6 kbit/s and 12 Mbit/s for all stations.
// - Valid user data reports code 40h in the device diagnostic message byte.
module fbd_core #(
  parameter int BLINK_CYCLES = `FBD_BLINK_HALF_NS / `FBD_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_cycle,
  input wire logic [6:0] station_addr,
  input wire logic [6:0] rx_addr,
  input wire logic slave_failsafe,
  output fbd_pkg::fbd_diag_t diag_block,
  output logic diag_block_wr,
  output logic diag_send,
  output logic diag_delete,
  output logic [7:0] diag_msg_code,
  output fbd_pkg::fbd_cycle_t cycle_cmd,
  output logic cycle_cmd_vld,
  output logic addr_match,
  output logic run_indicator,
  output logic data_exchange_indicator,
  output logic params_to_master
);
  // ==========================================================
  // Register bus
  logic [7:0] status_ff, nxt_status;
  logic [39:0] payload_ff, nxt_payload;
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic [15:0] base_ff, nxt_base;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic [7:0] msg_ff;
  fbd_pkg::fbd_mstate_t mst_ff;
  logic hwcfg_pulse;

  // One wait state: request is answered on the second edge it is held.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic be);
    merge8 = be ? nw : old;
  endfunction : merge8

  always_comb begin
    nxt_status = status_ff;
    nxt_payload = payload_ff;
    nxt_ctrl = ctrl_ff;
    nxt_base = base_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    hwcfg_pulse = 1'b0;
    if ((avs_read | avs_write) & ~ack_ff) begin
      nxt_ack = 1'b1;
    end
    if (avs_write & ack_ff) begin
      if (avs_address == `FBD_OFF_STATUS) begin
        nxt_status = merge8(status_ff, avs_writedata[7:0], avs_byteenable[0]);
      end else if (avs_address == `FBD_OFF_PAYLOAD) begin
        nxt_payload[7:0] = merge8(payload_ff[7:0], avs_writedata[7:0], avs_byteenable[0]);
        nxt_payload[15:8] = merge8(payload_ff[15:8], avs_writedata[15:8], avs_byteenable[1]);
        nxt_payload[23:16] = merge8(payload_ff[23:16], avs_writedata[23:16], avs_byteenable[2]);
        nxt_payload[31:24] = merge8(payload_ff[31:24], avs_writedata[31:24], avs_byteenable[3]);
      end else if (avs_address == `FBD_OFF_PAYLOAD_HI) begin
        nxt_payload[39:32] = merge8(payload_ff[39:32], avs_writedata[7:0], avs_byteenable[0]);
      end else if (avs_address == `FBD_OFF_CTRL) begin
        if (avs_byteenable[0]) begin
          nxt_ctrl = {1'b0, avs_writedata[2:0]};
          hwcfg_pulse = avs_writedata[`FBD_CTRL_HWCFG];
        end
      end else if (avs_address == `FBD_OFF_BASE) begin
        nxt_base[7:0] = merge8(base_ff[7:0], avs_writedata[7:0], avs_byteenable[0]);
        nxt_base[15:8] = merge8(base_ff[15:8], avs_writedata[15:8], avs_byteenable[1]);
      end
    end
    if (avs_read & ~ack_ff) begin
      if (avs_address == `FBD_OFF_STATUS) begin
        nxt_rdata = {24'h000000, status_ff};
      end else if (avs_address == `FBD_OFF_PAYLOAD) begin
        nxt_rdata = payload_ff[31:0];
      end else if (avs_address == `FBD_OFF_PAYLOAD_HI) begin
        nxt_rdata = {24'h000000, payload_ff[39:32]};
      end else if (avs_address == `FBD_OFF_CTRL) begin
        nxt_rdata = {28'h0000000, ctrl_ff};
      end else if (avs_address == `FBD_OFF_BASE) begin
        nxt_rdata = {16'h0000, base_ff};
      end else if (avs_address == `FBD_OFF_STATE) begin
        nxt_rdata = {30'h00000000, mst_ff};
      end else if (avs_address == `FBD_OFF_DIAG_MSG) begin
        nxt_rdata = {24'h000000, msg_ff};
      end else begin
        // Unmapped reads answer zero so software never stalls.
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= 8'h00;
      payload_ff <= 40'h0000000000;
      ctrl_ff <= 4'h0;
      base_ff <= 16'h0000;
      rdata_ff <= 32'h00000000;
      ack_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      payload_ff <= nxt_payload;
      ctrl_ff <= nxt_ctrl;
      base_ff <= nxt_base;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  // ==========================================================
  // Diagnostic release
  logic [7:0] prev_ff, nxt_prev;
  fbd_pkg::fbd_diag_t blk_ff, nxt_blk;
  logic wr_ff, nxt_wr, send_ff, nxt_send, del_ff, nxt_del;
  logic [7:0] nxt_msg;
  logic rise;

  // Reserved bits 2..7 take part only in the whole-byte comparison with the ignored value 03h.
  assign rise = status_ff[`FBD_BIT_VALID] & ~prev_ff[`FBD_BIT_VALID];

  always_comb begin
    nxt_prev = prev_ff;
    nxt_blk = blk_ff;
    nxt_wr = 1'b0;
    nxt_send = 1'b0;
    nxt_del = 1'b0;
    nxt_msg = msg_ff;
    if (cpu_cycle) begin
      nxt_prev = status_ff;
      if (status_ff != `FBD_STATUS_IGNORED) begin
        if (rise) begin
          nxt_blk.base = base_ff;
          nxt_blk.status = status_ff;
          nxt_blk.payload = payload_ff;
          nxt_wr = 1'b1;
          nxt_send = 1'b1;
          nxt_msg = `FBD_MSG_USER_VALID;
        end
        if (status_ff[`FBD_BIT_DELETE] & ~prev_ff[`FBD_BIT_DELETE]) begin
          nxt_del = 1'b1;
          // A diagnostic released in the same cycle keeps its valid code.
          if (!rise) begin
            nxt_msg = `FBD_MSG_NONE;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 8'h00;
      blk_ff <= '0;
      wr_ff <= 1'b0;
      send_ff <= 1'b0;
      del_ff <= 1'b0;
      msg_ff <= 8'h00;
    end else begin
      prev_ff <= nxt_prev;
      blk_ff <= nxt_blk;
      wr_ff <= nxt_wr;
      send_ff <= nxt_send;
      del_ff <= nxt_del;
      msg_ff <= nxt_msg;
    end
  end

  assign diag_block = blk_ff;
  assign diag_block_wr = wr_ff;
  assign diag_send = send_ff;
  assign diag_delete = del_ff;
  assign diag_msg_code = msg_ff;

  // ==========================================================
  // Master state
  fbd_pkg::fbd_mstate_t nxt_mst;
  logic ptm_ff, nxt_ptm, booted_ff, nxt_booted;
  fbd_pkg::fbd_cycle_t cmd_ff, nxt_cmd;
  logic cvld_ff, nxt_cvld;
  logic [31:0] blink_cnt_ff, nxt_blink_cnt;
  logic blink_ff, nxt_blink;
  logic run_mode;

  assign run_mode = ctrl_ff[`FBD_CTRL_RUN];

  always_comb begin
    nxt_mst = mst_ff;
    nxt_ptm = 1'b0;
    nxt_booted = 1'b1;
    nxt_cmd = cmd_ff;
    nxt_cvld = 1'b0;
    // Parameters go to the master on the first cycle after reset and per new configuration.
    if (!booted_ff || hwcfg_pulse) begin
      nxt_ptm = 1'b1;
    end
    case (mst_ff)
      fbd_pkg::FBD_OFFLINE: begin
        if (ctrl_ff[`FBD_CTRL_PARAMS]) begin
          nxt_mst = fbd_pkg::FBD_ONLINE;
        end
      end
      fbd_pkg::FBD_ONLINE: begin
        if (!ctrl_ff[`FBD_CTRL_PARAMS]) begin
          nxt_mst = fbd_pkg::FBD_OFFLINE;
        end else if (ctrl_ff[`FBD_CTRL_CONFIG]) begin
          nxt_mst = fbd_pkg::FBD_EXCHANGE;
        end
      end
      fbd_pkg::FBD_EXCHANGE: begin
        if (!ctrl_ff[`FBD_CTRL_PARAMS]) begin
          nxt_mst = fbd_pkg::FBD_OFFLINE;
        end else if (!ctrl_ff[`FBD_CTRL_CONFIG]) begin
          nxt_mst = fbd_pkg::FBD_ONLINE;
        end
      end
      default: begin
        nxt_mst = fbd_pkg::FBD_OFFLINE;
      end
    endcase
    if (cpu_cycle && mst_ff == fbd_pkg::FBD_EXCHANGE) begin
      nxt_cvld = 1'b1;
      nxt_cmd.copy_in = 1'b1;
      if (run_mode) begin
        nxt_cmd.gc = fbd_pkg::FBD_GC_OPERATE;
        nxt_cmd.zero_len = 1'b0;
        nxt_cmd.zero_data = 1'b0;
        nxt_cmd.send_out = 1'b1;
      end else begin
        nxt_cmd.gc = fbd_pkg::FBD_GC_CLEAR;
        nxt_cmd.zero_len = slave_failsafe;
        nxt_cmd.zero_data = ~slave_failsafe;
        nxt_cmd.send_out = 1'b1;
      end
    end
    nxt_blink_cnt = blink_cnt_ff + 32'h00000001;
    nxt_blink = blink_ff;
    if (blink_cnt_ff >= BLINK_CYCLES - 1) begin
      nxt_blink_cnt = 32'h00000000;
      nxt_blink = ~blink_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_ff <= fbd_pkg::FBD_OFFLINE;
      ptm_ff <= 1'b0;
      booted_ff <= 1'b0;
      cmd_ff <= '0;
      cvld_ff <= 1'b0;
      blink_cnt_ff <= 32'h00000000;
      blink_ff <= 1'b0;
    end else begin
      mst_ff <= nxt_mst;
      ptm_ff <= nxt_ptm;
      booted_ff <= nxt_booted;
      cmd_ff <= nxt_cmd;
      cvld_ff <= nxt_cvld;
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
    end
  end

  // Bit rate selection lives in the serial engine outside; slaves follow the master's rate.
  assign cycle_cmd = cmd_ff;
  assign cycle_cmd_vld = cvld_ff;
  assign params_to_master = ptm_ff;
  assign run_indicator = (mst_ff != fbd_pkg::FBD_OFFLINE);
  assign addr_match = (mst_ff != fbd_pkg::FBD_OFFLINE) && (rx_addr == station_addr);
  assign data_exchange_indicator = (mst_ff == fbd_pkg::FBD_EXCHANGE) && (run_mode | blink_ff);

  // ==========================================================
  // Checks
  a_diag_send_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cpu_cycle && rise && status_ff != `FBD_STATUS_IGNORED) |=> diag_send)
    else $error("diagnostic not sent on rising valid bit");
  a_ignore_three: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status_ff == `FBD_STATUS_IGNORED) |=> !diag_send)
    else $error("status 03h produced a diagnostic");
  a_block_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    diag_block_wr |-> (diag_block.payload == $past(payload_ff) && diag_block.base == $past(base_ff)))
    else $error("diagnostic block contents wrong");
  a_msg_code: assert property (@(posedge core_clk) disable iff (!rst_n)
    diag_send |-> diag_msg_code == `FBD_MSG_USER_VALID)
    else $error("valid diagnostic code missing");
  a_stop_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cycle_cmd_vld && $past(!run_mode)) |-> (cycle_cmd.gc == fbd_pkg::FBD_GC_CLEAR && cycle_cmd.copy_in))
    else $error("STOP cycle without Clear");
  a_run_operate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cycle_cmd_vld && $past(run_mode)) |-> (cycle_cmd.gc == fbd_pkg::FBD_GC_OPERATE && !cycle_cmd.zero_data))
    else $error("RUN cycle without Operate");
  a_failsafe_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cycle_cmd_vld && $past(!run_mode)) |-> (cycle_cmd.zero_len == $past(slave_failsafe)))
    else $error("fail-safe telegram length wrong");
  a_offline_dark: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mst_ff == fbd_pkg::FBD_OFFLINE) |-> (!run_indicator && !data_exchange_indicator && !addr_match))
    else $error("indicator lit while offline");
  a_online_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (mst_ff == fbd_pkg::FBD_OFFLINE && ctrl_ff[`FBD_CTRL_PARAMS]) |=> run_indicator)
    else $error("master did not go online");
endmodule : fbd_core

/* File: verif/fbd_slave_model.sv */
// Behavioural fieldbus slave station that takes the master's cyclic telegrams.
`timescale 1ns/1ps
// ==========================================
// Slave station model
module fbd_slave_model #(
  parameter logic [6:0] ADDR = 7'h05
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic failsafe_mode,
  input wire fbd_pkg::fbd_cycle_t cycle_cmd,
  input wire logic cycle_cmd_vld,
  output logic [6:0] rx_addr,
  output logic slave_failsafe,
  output int tel_cnt,
  output fbd_pkg::fbd_cycle_t last_cmd
);
  // The station adopts the master's bit rate, so it takes telegrams on the master's own clock.
  assign rx_addr = ADDR;
  assign slave_failsafe = failsafe_mode;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tel_cnt <= 0;
      last_cmd <= '0;
    end else if (cycle_cmd_vld) begin
      tel_cnt <= tel_cnt + 1;
      last_cmd <= cycle_cmd;
    end
  end
endmodule : fbd_slave_model

/* File: verif/tb_top.sv */
// Self-checking testbench for the fieldbus diagnostic and master state block.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] st;
    logic snd;
    logic del;
    logic [7:0] msg;
  } fbd_row_t;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, cpu_cycle, failsafe_mode, slave_failsafe;
  logic diag_block_wr, diag_send, diag_delete, cycle_cmd_vld, addr_match, run_indicator;
  logic data_exchange_indicator, params_to_master;
  logic [7:0] avs_address, diag_msg_code;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [6:0] station_addr, rx_addr;
  fbd_pkg::fbd_diag_t diag_block;
  fbd_pkg::fbd_cycle_t cycle_cmd, last_cmd;
  int tel_cnt, error_cnt = 0, checked = 0, sends = 0, dels = 0, blks = 0, prm = 0, cyc = 0;
  int s0, d0, b0, t0, p0, hi;
  fbd_row_t rows [10] = '{'{8'h00, 1'h0, 1'h0, 8'h00}, '{8'h01, 1'h1, 1'h0, 8'h40},
    '{8'h01, 1'h0, 1'h0, 8'h40}, '{8'h00, 1'h0, 1'h0, 8'h40}, '{8'h03, 1'h0, 1'h0, 8'h40},
    '{8'h00, 1'h0, 1'h0, 8'h40}, '{8'h02, 1'h0, 1'h1, 8'h00}, '{8'h05, 1'h1, 1'h0, 8'h40},
    '{8'hFC, 1'h0, 1'h0, 8'h40}, '{8'hFD, 1'h1, 1'h0, 8'h40}};

  fbd_core #(.BLINK_CYCLES(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_cycle(cpu_cycle), .station_addr(station_addr), .rx_addr(rx_addr),
    .slave_failsafe(slave_failsafe), .diag_block(diag_block), .diag_block_wr(diag_block_wr),
    .diag_send(diag_send), .diag_delete(diag_delete), .diag_msg_code(diag_msg_code),
    .cycle_cmd(cycle_cmd), .cycle_cmd_vld(cycle_cmd_vld), .addr_match(addr_match),
    .run_indicator(run_indicator), .data_exchange_indicator(data_exchange_indicator),
    .params_to_master(params_to_master));
  fbd_slave_model slave (.core_clk(core_clk), .rst_n(rst_n), .failsafe_mode(failsafe_mode),
    .cycle_cmd(cycle_cmd), .cycle_cmd_vld(cycle_cmd_vld), .rx_addr(rx_addr),
    .slave_failsafe(slave_failsafe), .tel_cnt(tel_cnt), .last_cmd(last_cmd));

  // ==========================================
  // Clock, pulse counters and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (diag_send === 1'b1) sends <= sends + 1;
    if (diag_delete === 1'b1) dels <= dels + 1;
    if (diag_block_wr === 1'b1) blks <= blks + 1;
    if (params_to_master === 1'b1) prm <= prm + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk
  // Called right after a rising edge; waitrequest and read data are taken as they stood at each rising edge.
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    logic wq;
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge core_clk);
      wq = avs_waitrequest;
      q = avs_readdata;
      n++;
    end while (wq !== 1'b0 && n < 50);
    if (n >= 50) chk(1, 0, "bus stuck");
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic tick;
    cpu_cycle <= 1'b1;
    @(posedge core_clk);
    cpu_cycle <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : tick
  task automatic ind;
    hi = 0;
    repeat (16) begin
      @(negedge core_clk);
      if (data_exchange_indicator === 1'b1) hi++;
    end
    @(posedge core_clk);
  endtask : ind
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ==========================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    cpu_cycle = 1'b0;
    failsafe_mode = 1'b0;
    station_addr = 7'h05;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk({run_indicator, data_exchange_indicator, addr_match, diag_msg_code}, 0, "reset state");
    chk(prm, 1, "params after power-on");
    @(posedge core_clk);
    bus(1'b0, 8'h10, 32'h0000_0123);
    bus(1'b0, 8'h04, 32'h4433_2211);
    bus(1'b0, 8'h08, 32'h0000_0055);
    bus(1'b1, 8'h04, 32'h0);
    chk(q, 32'h4433_2211, "payload readback");
    bus(1'b0, 8'h1C, 32'hFFFF_FFFF);
    bus(1'b1, 8'h1C, 32'h0);
    chk(q, 32'h0, "unmapped read");
    bus(1'b1, 8'h00, 32'h0);
    chk(q, 32'h0, "status after unmapped write");
    $display("test registers done");
    for (int i = 0; i < 10; i++) begin
      s0 = sends;
      d0 = dels;
      b0 = blks;
      bus(1'b0, 8'h00, {24'h0, rows[i].st});
      tick();
      chk(sends - s0, rows[i].snd, "send pulses");
      chk(blks - b0, rows[i].snd, "block writes");
      chk(dels - d0, rows[i].del, "delete pulses");
      chk(diag_msg_code, rows[i].msg, "message code");
      if (rows[i].snd) chk(diag_block, {16'h0123, rows[i].st, 40'h55_4433_2211}, "block");
    end
    $display("test diagnostic table done");
    t0 = tel_cnt;
    bus(1'b0, 8'h0C, 32'h2);
    repeat (2) @(posedge core_clk);
    tick();
    @(negedge core_clk);
    chk({run_indicator, addr_match, data_exchange_indicator}, 3'h6, "online");
    chk(tel_cnt - t0, 0, "no telegrams before configuration");
    @(posedge core_clk);
    station_addr <= 7'h06;
    @(negedge core_clk);
    chk(addr_match, 0, "foreign address");
    @(posedge core_clk);
    bus(1'b0, 8'h0C, 32'h6);
    repeat (2) @(posedge core_clk);
    bus(1'b1, 8'h14, 32'h0);
    chk(q, 32'h2, "exchange state");
    for (int fs = 0; fs < 2; fs++) begin
      failsafe_mode <= fs[0];
      t0 = tel_cnt;
      tick();
      chk(tel_cnt - t0, 1, "stop telegram");
      chk(last_cmd.gc, fbd_pkg::FBD_GC_CLEAR, "stop command");
      chk(last_cmd.zero_len, fs[0], "zero length");
      chk(last_cmd.zero_data, !fs[0], "zero data");
      chk(last_cmd.copy_in, 1'b1, "inputs copied in stop");
    end
    ind();
    chk(hi > 0 && hi < 16, 1, "blinking in stop");
    bus(1'b0, 8'h0C, 32'h7);
    repeat (2) @(posedge core_clk);
    tick();
    chk(last_cmd.gc, fbd_pkg::FBD_GC_OPERATE, "run command");
    chk({last_cmd.zero_len, last_cmd.zero_data, last_cmd.send_out}, 3'h1, "run outputs");
    chk(last_cmd.copy_in, 1'b1, "inputs copied in run");
    ind();
    chk(hi, 16, "steady in run");
    $display("test master states done");
    p0 = prm;
    bus(1'b0, 8'h0C, 32'hF);
    repeat (2) @(posedge core_clk);
    chk(prm - p0, 1, "params on new configuration");
    rst_n <= 1'b0;
    @(negedge core_clk);
    chk({run_indicator, data_exchange_indicator, diag_msg_code}, 0, "second reset");
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(prm - p0, 2, "params after second reset");
    $display("test reset done");
    results();
  end
endmodule : tb_top
